//--- pkg/pwm_consts.svh
// Register offsets, field positions, reset values and timing counts of the
// compare PWM generator.
// Assumes inclusion by bare name from package and design files alike.
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (word addresses on the plain register port)
// ----------------------------------------------------------------------
`define OFS_CTRL_ONE 3'h0
`define OFS_CTRL_TWO 3'h1
`define OFS_PRIMARY 3'h2
`define OFS_SECONDARY 3'h3
`define OFS_PERIOD 3'h4
`define OFS_COUNT 3'h5

// ----------------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------------
`define POS_MODE_LO 0
`define POS_TRIG_MODE 3
`define POS_FLAG_A 4
`define POS_FLAG_B 5
`define POS_FLAG_C 6
`define POS_EN_A 7
`define POS_EN_B 8
`define POS_EN_C 9
`define POS_TBSEL_LO 10
`define POS_IDLE_STOP 13
`define CTRL_ONE_MASK 16'h3FFF

// ----------------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------------
`define POS_SYNC_LO 0
`define POS_TRIG_SEL 7
`define POS_FLT_OUT 14
`define POS_FLT_HOLD 15
`define CTRL_TWO_MASK 16'hC09F

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define RST_CTRL_ONE 16'h0000
`define RST_CTRL_TWO 16'h000C
`define RST_WORD 16'h0000
`define SYNC_SELF 5'h1F
`define SYNC_WIDTH 5
`define TICK_SYNC_STAGES 3

`endif

//--- pkg/pwm_pkg.sv
// Types shared by the compare PWM generator files.
// Assumes pwm_consts.svh sits beside it on the include path.
package pwm_pkg;
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_SS_LO = 3'h1,
        MODE_SS_HI = 3'h2,
        MODE_SC_TOG = 3'h3,
        MODE_DC_SS = 3'h4,
        MODE_DC_CONT = 3'h5,
        MODE_EDGE = 3'h6,
        MODE_CENTER = 3'h7
    } out_mode_type;

    typedef enum logic [2:0] {
        TB_TIMER_B = 3'h0,
        TB_TIMER_C = 3'h1,
        TB_UNIMP_2 = 3'h2,
        TB_UNIMP_3 = 3'h3,
        TB_TIMER_A = 3'h4,
        TB_RES_5 = 3'h5,
        TB_RES_6 = 3'h6,
        TB_PERIPH = 3'h7
    } tb_sel_type;

    // Gray order along the usual path: idle, running, fault
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_FAULT = 2'b11
    } pwm_state_type;
endpackage

//--- hw/tick_sync.sv
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes a single clock; input may change at any time.
`timescale 1ns/1ns
`default_nettype none
module tick_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Level in and filtered level out
    input wire logic din,
    output logic dout
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    // First stage only feeds the second, so metastability never leaks
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dout <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            dout <= s3_ff;
        end
    end
endmodule
`default_nettype wire

//--- hw/compare_pwm_generator.sv
// Compare channel in PWM operation: time base, double-buffered duty,
// fault override and the register port.
// Assumes timer prescaler ticks, fault pins and comparator arrive
// asynchronously; the register master shares REF_CLK.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_consts.svh"
module compare_pwm_generator #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [2:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    output logic [15:0] REG_RDATA,
    // Time base ticks from timer prescalers
    input wire logic TIMER_A_TICK,
    input wire logic TIMER_B_TICK,
    input wire logic TIMER_C_TICK,
    // System state
    input wire logic CPU_IDLE,
    // Fault sources
    input wire logic FAULT_INPUT_A,
    input wire logic FAULT_INPUT_B,
    input wire logic COMPARATOR_ONE_OUT,
    // Output pin and sync out
    output logic PWM_OUTPUT_PIN,
    output logic PWM_OUTPUT_PIN_OE_N,
    output logic SYNC_OUT
);
    import pwm_pkg::*;

    generate
        if (WIDTH != 16) begin : g_bad_width
            $error("compare_pwm_generator supports WIDTH 16 only");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == MODE_EDGE) || (m == MODE_CENTER);
    endfunction

    function automatic logic rising(input logic now, input logic was);
        rising = now && !was;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] ctrl_one_ff;
    logic [15:0] ctrl_two_ff;
    logic [15:0] primary_compare_value_ff;
    logic [15:0] secondary_compare_value_ff;
    logic [15:0] timer_period_value_ff;
    logic [15:0] act_primary_ff;
    logic [15:0] act_secondary_ff;
    logic [15:0] count_ff;
    logic dir_down_ff;
    logic out_ff;
    pwm_state_type state_ff;
    logic [2:0] tick_prev_ff;
    logic [2:0] tick_lvl;
    logic tick_a_lvl;
    logic [2:0] fault_sync;
    logic idle_sync;

    logic [2:0] output_mode_select;
    logic [2:0] timebase_source_select;
    logic idle_stop_control;
    logic [2:0] fault_en;
    logic [2:0] fault_flags;
    logic fault_output_level;
    logic fault_hold_select;
    logic pwm_on;
    logic tick;
    logic period_end;
    logic [2:0] fault_event;
    logic any_fault_live;
    logic any_flag;
    logic release_now;
    logic wr_one;
    assign output_mode_select = ctrl_one_ff[`POS_MODE_LO +: 3];
    assign timebase_source_select = ctrl_one_ff[`POS_TBSEL_LO +: 3];
    assign idle_stop_control = ctrl_one_ff[`POS_IDLE_STOP];
    assign fault_en = {ctrl_one_ff[`POS_EN_C], ctrl_one_ff[`POS_EN_B],
                       ctrl_one_ff[`POS_EN_A]};
    assign fault_flags = {ctrl_one_ff[`POS_FLAG_C], ctrl_one_ff[`POS_FLAG_B],
                          ctrl_one_ff[`POS_FLAG_A]};
    assign fault_output_level = ctrl_two_ff[`POS_FLT_OUT];
    assign fault_hold_select = ctrl_two_ff[`POS_FLT_HOLD];
    assign pwm_on = is_pwm(output_mode_select);
    assign wr_one = REG_WRITE && (REG_ADDR == `OFS_CTRL_ONE);

    // ------------------------------------------------------------------
    // Synchronisers for pins and foreign ticks
    // ------------------------------------------------------------------
    logic [5:0] async_in;
    logic [5:0] async_out;
    assign async_in = {CPU_IDLE, COMPARATOR_ONE_OUT, FAULT_INPUT_B,
                       FAULT_INPUT_A, TIMER_C_TICK, TIMER_B_TICK};
    assign tick_lvl = {tick_a_lvl, async_out[1:0]};
    assign fault_sync = async_out[4:2];
    assign idle_sync = async_out[5];

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_sync
            tick_sync u_sync (
                .clk(REF_CLK),
                .reset_n(RESET_N),
                .din(async_in[g]),
                .dout(async_out[g])
            );
        end
    endgenerate

    tick_sync u_sync_a (
        .clk(REF_CLK),
        .reset_n(RESET_N),
        .din(TIMER_A_TICK),
        .dout(tick_a_lvl)
    );

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            tick_prev_ff <= 3'h0;
        end else begin
            tick_prev_ff <= tick_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Time base selection
    // ------------------------------------------------------------------
    // Reserved and unimplemented codes give no ticks, so the count stalls
    always_comb begin
        case (timebase_source_select)
            TB_PERIPH: tick = 1'b1;
            TB_TIMER_A: tick = rising(tick_lvl[2], tick_prev_ff[2]);
            TB_TIMER_C: tick = rising(tick_lvl[1], tick_prev_ff[1]);
            TB_TIMER_B: tick = rising(tick_lvl[0], tick_prev_ff[0]);
            default: tick = 1'b0;
        endcase
    end

    logic run;
    assign run = pwm_on && tick && !(idle_stop_control && idle_sync);

    // Period end is the count meeting the period value in edge mode, or reaching zero while counting down in center mode
    assign period_end = run && (output_mode_select == MODE_EDGE
                        ? (count_ff == timer_period_value_ff)
                        : (dir_down_ff && count_ff == 16'h0000));

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            count_ff <= `RST_WORD;
            dir_down_ff <= 1'b0;
        end else if (!pwm_on) begin
            count_ff <= `RST_WORD;
            dir_down_ff <= 1'b0;
        end else if (run) begin
            if (output_mode_select == MODE_EDGE) begin
                dir_down_ff <= 1'b0;
                if (count_ff == timer_period_value_ff) begin
                    count_ff <= `RST_WORD;
                end else begin
                    count_ff <= count_ff + 16'h0001;
                end
            end else if (!dir_down_ff) begin
                // Center mode: up to period, then back down to zero
                if (count_ff == timer_period_value_ff) begin
                    dir_down_ff <= (timer_period_value_ff != 16'h0000);
                    if (timer_period_value_ff != 16'h0000) begin
                        count_ff <= count_ff - 16'h0001;
                    end
                end else begin
                    count_ff <= count_ff + 16'h0001;
                end
            end else if (count_ff == 16'h0000) begin
                dir_down_ff <= 1'b0;
                count_ff <= 16'h0001;
            end else begin
                count_ff <= count_ff - 16'h0001;
            end
        end
    end

    // Self sync pulse marks each period end
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            SYNC_OUT <= 1'b0;
        end else begin
            SYNC_OUT <= period_end;
        end
    end

    // ------------------------------------------------------------------
    // Duty double buffer
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            act_primary_ff <= `RST_WORD;
            act_secondary_ff <= `RST_WORD;
        end else if (!pwm_on || period_end) begin
            act_primary_ff <= primary_compare_value_ff;
            act_secondary_ff <= secondary_compare_value_ff;
        end
    end

    // ------------------------------------------------------------------
    // Fault detection and state
    // ------------------------------------------------------------------
    assign fault_event = fault_sync & fault_en & {3{pwm_on}};
    assign any_fault_live = |fault_event;
    assign any_flag = |(fault_flags & fault_en);
    // Hold select 1: leave once flags are cleared; 0: at new period
    assign release_now = !any_fault_live &&
                         (fault_hold_select ? !any_flag : period_end);

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state_ff <= ST_IDLE;
        end else if (!pwm_on) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: state_ff <= ST_RUN;
                ST_RUN: begin
                    if (any_fault_live) begin
                        state_ff <= ST_FAULT;
                    end
                end
                ST_FAULT: begin
                    if (release_now) begin
                        state_ff <= ST_RUN;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output waveform
    // ------------------------------------------------------------------
    logic wave;
    always_comb begin
        if (act_secondary_ff > timer_period_value_ff) begin
            wave = 1'b1;
        end else if (output_mode_select == MODE_EDGE) begin
            // Low from the primary match up to period end
            wave = (count_ff < act_primary_ff);
        end else begin
            wave = (count_ff >= act_primary_ff) &&
                   (count_ff < act_secondary_ff);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            out_ff <= 1'b0;
        end else if (!pwm_on || state_ff == ST_IDLE) begin
            out_ff <= 1'b0;
        end else if (state_ff == ST_FAULT || any_fault_live) begin
            out_ff <= fault_output_level;
        end else begin
            out_ff <= wave;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            PWM_OUTPUT_PIN <= 1'b0;
            PWM_OUTPUT_PIN_OE_N <= 1'b1;
        end else begin
            PWM_OUTPUT_PIN <= out_ff;
            PWM_OUTPUT_PIN_OE_N <= !pwm_on;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ctrl_one_ff <= `RST_CTRL_ONE;
        end else begin
            if (wr_one) begin
                ctrl_one_ff <= REG_WDATA & `CTRL_ONE_MASK;
            end
            if (wr_one) begin
                ctrl_one_ff[`POS_FLAG_A +: 3] <= REG_WDATA[`POS_FLAG_A +: 3]
                                               | fault_event;
            end else begin
                ctrl_one_ff[`POS_FLAG_A +: 3] <= fault_flags
                                               | fault_event;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ctrl_two_ff <= `RST_CTRL_TWO;
        end else if (REG_WRITE && REG_ADDR == `OFS_CTRL_TWO) begin
            ctrl_two_ff <= REG_WDATA & `CTRL_TWO_MASK;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            primary_compare_value_ff <= `RST_WORD;
            secondary_compare_value_ff <= `RST_WORD;
            timer_period_value_ff <= `RST_WORD;
        end else if (REG_WRITE) begin
            if (REG_ADDR == `OFS_PRIMARY) begin
                primary_compare_value_ff <= REG_WDATA;
            end
            if (REG_ADDR == `OFS_SECONDARY) begin
                secondary_compare_value_ff <= REG_WDATA;
            end
            if (REG_ADDR == `OFS_PERIOD) begin
                timer_period_value_ff <= REG_WDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_READ) begin
            case (REG_ADDR)
                `OFS_CTRL_ONE: REG_RDATA <= ctrl_one_ff & `CTRL_ONE_MASK;
                `OFS_CTRL_TWO: REG_RDATA <= ctrl_two_ff;
                `OFS_PRIMARY: REG_RDATA <= primary_compare_value_ff;
                `OFS_SECONDARY: REG_RDATA <= secondary_compare_value_ff;
                `OFS_PERIOD: REG_RDATA <= timer_period_value_ff;
                `OFS_COUNT: REG_RDATA <= count_ff;
                default: REG_RDATA <= 16'h0000;
            endcase
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

//--- dv/pwm_load_model.sv
// Load on the PWM pin: tallies high and driven cycles in a window.
// Assumes one sample per REF_CLK edge; clr opens a new window.
`timescale 1ns/1ns
`default_nettype none
module pwm_load_model (
    // Clock
    input wire logic clk,
    // Window control
    input wire logic clr,
    // Pin as seen by the load
    input wire logic pin,
    input wire logic oe_n,
    // Tallies
    output var logic [15:0] high_cnt,
    output var logic [15:0] drive_cnt
);
    logic load_level;
    // Released pin sinks through the pull-down, never holds its last level
    assign load_level = oe_n ? 1'b0 : pin;
    always @(posedge clk) begin
        if (clr) begin
            high_cnt <= 16'h0000;
            drive_cnt <= 16'h0000;
        end else begin
            high_cnt <= high_cnt + {15'h0000, load_level};
            drive_cnt <= drive_cnt + {15'h0000, ~oe_n};
        end
    end
endmodule
`default_nettype wire

//--- dv/compare_pwm_generator_sva.sv
// Port checks for the compare PWM generator.
// Assumes one clock and one-cycle register strobes.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_consts.svh"
module compare_pwm_generator_sva #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [2:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic [15:0] REG_RDATA,
    // Fault sources and system state
    input wire logic CPU_IDLE,
    input wire logic FAULT_INPUT_A,
    input wire logic FAULT_INPUT_B,
    input wire logic COMPARATOR_ONE_OUT,
    // Outputs
    input wire logic PWM_OUTPUT_PIN,
    input wire logic PWM_OUTPUT_PIN_OE_N,
    input wire logic SYNC_OUT
);
    logic [15:0] ctrl_ff;
    logic [15:0] ctrl2_ff;
    logic [15:0] per_ff;
    logic [16:0] gap_ff;
    logic steady_ff;
    logic pwm;
    logic fault_on;
    logic [2:0] src_vec;
    assign pwm = (ctrl_ff[2:1] == 2'b11);
    assign src_vec = {COMPARATOR_ONE_OUT & ctrl_ff[9],
        FAULT_INPUT_B & ctrl_ff[8], FAULT_INPUT_A & ctrl_ff[7]} & {3{pwm}};
    assign fault_on = |src_vec;
    // ------------------------------------------------------------
    // Shadows of the control and period registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ctrl_ff <= `RST_CTRL_ONE;
            ctrl2_ff <= `RST_CTRL_TWO;
            per_ff <= `RST_WORD;
        end else if (REG_WRITE) begin
            if (REG_ADDR == `OFS_CTRL_ONE) ctrl_ff <= REG_WDATA & `CTRL_ONE_MASK;
            if (REG_ADDR == `OFS_CTRL_TWO) ctrl2_ff <= REG_WDATA & `CTRL_TWO_MASK;
            if (REG_ADDR == `OFS_PERIOD) per_ff <= REG_WDATA;
        end
    end
    // Gap between period ends; any write or idle spoils the measurement
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N || SYNC_OUT) gap_ff <= 17'h00001;
        else gap_ff <= gap_ff + 17'h00001;
        if (!RESET_N || REG_WRITE || CPU_IDLE) steady_ff <= 1'b0;
        else if (SYNC_OUT) steady_ff <= 1'b1;
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence s_off4;
        (!pwm)[*4];
    endsequence
    sequence s_pwm4;
        pwm[*4];
    endsequence
    sequence s_src_held;
        (src_vec != 3'b000 && $stable(src_vec))[*6];
    endsequence
    unmapped_rd_a: assert property (
        REG_READ && REG_ADDR[2:1] == 2'b11 |=> REG_RDATA == 16'h0000)
        else $error("unmapped read returned data");
    ctrl_rd_a: assert property (
        REG_READ && REG_ADDR == `OFS_CTRL_ONE |=>
        (REG_RDATA & 16'hFF8F) == ($past(ctrl_ff) & 16'hFF8F))
        else $error("control one readback wrong");
    ctrl2_rd_a: assert property (
        REG_READ && REG_ADDR == `OFS_CTRL_TWO |=> REG_RDATA == $past(ctrl2_ff))
        else $error("control two readback wrong");
    off_quiet_a: assert property (
        s_off4 |-> !PWM_OUTPUT_PIN && PWM_OUTPUT_PIN_OE_N)
        else $error("disabled channel drives its pin");
    count_off_a: assert property (
        s_off4 ##0 (REG_READ && REG_ADDR == `OFS_COUNT) |=> REG_RDATA == 16'h0000)
        else $error("disabled channel count not zero");
    pwm_drive_a: assert property (
        s_pwm4 |-> !PWM_OUTPUT_PIN_OE_N)
        else $error("pwm mode pin not driven");
    period_len_a: assert property (
        SYNC_OUT && steady_ff && ctrl_ff[12:10] == 3'h7 |->
        gap_ff == {1'b0, per_ff} + 17'h00001)
        else $error("period length not period value plus one");
    fault_force_a: assert property (
        fault_on[*8] ##1 fault_on[*2] |-> PWM_OUTPUT_PIN == ctrl2_ff[14])
        else $error("fault level not forced on pin");
    fault_flag_a: assert property (
        s_src_held ##0 (REG_READ && REG_ADDR == `OFS_CTRL_ONE) |=>
        (REG_RDATA[6:4] & $past(src_vec)) == $past(src_vec))
        else $error("fault flag not set");
endmodule
bind compare_pwm_generator compare_pwm_generator_sva #(.WIDTH(WIDTH))
    u_compare_pwm_generator_sva (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_RDATA(REG_RDATA), .CPU_IDLE(CPU_IDLE),
    .FAULT_INPUT_A(FAULT_INPUT_A), .FAULT_INPUT_B(FAULT_INPUT_B),
    .COMPARATOR_ONE_OUT(COMPARATOR_ONE_OUT), .SYNC_OUT(SYNC_OUT),
    .PWM_OUTPUT_PIN(PWM_OUTPUT_PIN),
    .PWM_OUTPUT_PIN_OE_N(PWM_OUTPUT_PIN_OE_N));
`default_nettype wire

//--- dv/compare_pwm_generator_tb_top.sv
// Self-checking bench for the compare PWM generator.
// Assumes pwm_consts.svh on the include path and the load model beside it.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_consts.svh"
module compare_pwm_generator_tb_top;
    logic REF_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [2:0] REG_ADDR = 3'h0;
    logic [15:0] REG_WDATA = 16'h0000;
    logic REG_WRITE = 1'b0;
    logic REG_READ = 1'b0;
    logic [15:0] REG_RDATA;
    logic [2:0] ticks = 3'h0;
    logic [2:0] faults = 3'h0;
    logic CPU_IDLE = 1'b0;
    logic clr = 1'b1;
    logic PWM_OUTPUT_PIN;
    logic PWM_OUTPUT_PIN_OE_N;
    logic [15:0] high_cnt;
    logic [15:0] drive_cnt;
    logic [15:0] c0;
    logic [15:0] c1;
    logic [2:0] tb_code [3] = '{3'h4, 3'h0, 3'h1};
    int n_fail = 0;
    int cmp_count = 0;
    int cfg_q[$];
    int p, d, s, e, k, j;
    always #10 REF_CLK = ~REF_CLK;
    compare_pwm_generator u_compare_pwm_generator (.REF_CLK(REF_CLK),
        .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA),
        .TIMER_A_TICK(ticks[0]), .TIMER_B_TICK(ticks[1]),
        .TIMER_C_TICK(ticks[2]), .CPU_IDLE(CPU_IDLE),
        .FAULT_INPUT_A(faults[0]), .FAULT_INPUT_B(faults[1]),
        .COMPARATOR_ONE_OUT(faults[2]), .PWM_OUTPUT_PIN(PWM_OUTPUT_PIN),
        .PWM_OUTPUT_PIN_OE_N(PWM_OUTPUT_PIN_OE_N), .SYNC_OUT());
    pwm_load_model u_pwm_load_model (.clk(REF_CLK), .clr(clr),
        .pin(PWM_OUTPUT_PIN), .oe_n(PWM_OUTPUT_PIN_OE_N),
        .high_cnt(high_cnt), .drive_cnt(drive_cnt));
    // ------------------------------------------------------------
    // Bus cycles, window and compare
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WRITE <= 1'b1;
        @(posedge REF_CLK);
        REG_WRITE <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_READ <= 1'b1;
        @(posedge REF_CLK);
        REG_READ <= 1'b0;
        @(negedge REF_CLK);
        v = REG_RDATA;
    endtask
    task automatic measure(input int n);
        @(posedge REF_CLK);
        clr <= 1'b1;
        @(posedge REF_CLK);
        clr <= 1'b0;
        repeat (n) @(posedge REF_CLK);
        @(negedge REF_CLK);
    endtask
    task automatic tick(input int i);
        @(posedge REF_CLK);
        ticks[i] <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        ticks[i] <= 1'b0;
        repeat (4) @(posedge REF_CLK);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Limit only catches a hang
    initial begin
        #(20 * 20000);
        n_fail++;
        test_done();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(20));
        repeat (2) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        rd(`OFS_CTRL_ONE, c0);
        chk(c0, `RST_CTRL_ONE);
        rd(`OFS_CTRL_TWO, c0);
        chk(c0, `RST_CTRL_TWO);
        for (k = 6; k < 8; k++) begin
            wr(3'(k), 16'hFFFF);
            rd(3'(k), c0);
            chk(c0, 16'h0000);
        end
        wr(`OFS_CTRL_ONE, 16'hC000);
        rd(`OFS_CTRL_ONE, c0);
        chk(c0, 16'h0000);
        for (k = 0; k < 8; k++) begin
            wr(`OFS_CTRL_ONE, 16'h1C00 | 16'(k));
            repeat (5) @(posedge REF_CLK);
            chk({14'h0, PWM_OUTPUT_PIN_OE_N, PWM_OUTPUT_PIN},
                (k >= 6) ? 16'h0000 : 16'h0002);
        end
        wr(`OFS_CTRL_TWO, 16'h001F);
        for (k = 0; k < 4; k++) cfg_q.push_back(9);
        for (k = 0; k < 4; k++) cfg_q.push_back($urandom_range(10, 0));
        cfg_q = {cfg_q, 9, 3, 10, 0, 0, 0};
        for (k = 0; k < 4; k++) begin
            p = cfg_q.pop_front();
            cfg_q = {cfg_q, p, cfg_q[3], 0};
        end
        for (k = 0; k < 4; k++) void'(cfg_q.pop_front());
        while (cfg_q.size() > 0) begin
            p = cfg_q.pop_front();
            d = cfg_q.pop_front();
            s = cfg_q.pop_front();
            wr(`OFS_CTRL_ONE, 16'h1C00);
            wr(`OFS_PRIMARY, 16'(d));
            wr(`OFS_SECONDARY, 16'(s));
            wr(`OFS_PERIOD, 16'(p));
            wr(`OFS_CTRL_ONE, 16'h1C06);
            repeat (3 * (p + 1) + 8) @(posedge REF_CLK);
            measure(3 * (p + 1));
            e = (s > p) ? p + 1 : ((d < p + 1) ? d : p + 1);
            chk(high_cnt, 16'(3 * e));
            chk(drive_cnt, 16'(3 * (p + 1)));
        end
        wr(`OFS_PERIOD, 16'h0009);
        for (k = 0; k < 3; k++) begin
            wr(`OFS_CTRL_ONE, {3'h0, tb_code[k], 10'h006});
            rd(`OFS_COUNT, c0);
            for (j = 0; j < 3; j++) begin
                tick(k);
                tick((k + 1) % 3);
            end
            rd(`OFS_COUNT, c1);
            chk(c1, (c0 + 16'h0003) % 16'h000A);
        end
        wr(`OFS_CTRL_ONE, 16'h3C06);
        CPU_IDLE <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        rd(`OFS_COUNT, c0);
        rd(`OFS_COUNT, c1);
        chk(c1, c0);
        wr(`OFS_CTRL_ONE, 16'h1C06);
        rd(`OFS_COUNT, c0);
        rd(`OFS_COUNT, c1);
        chk(c1, (c0 + 16'h0002) % 16'h000A);
        @(posedge REF_CLK);
        CPU_IDLE <= 1'b0;
        wr(`OFS_CTRL_TWO, 16'h401F);
        wr(`OFS_PRIMARY, 16'h0002);
        for (k = 0; k < 3; k++) begin
            wr(`OFS_CTRL_ONE, 16'h1C00 | (16'h0080 << k));
            faults[k] <= 1'b1;
            repeat (8) @(posedge REF_CLK);
            rd(`OFS_CTRL_ONE, c0);
            chk(c0 & (16'h0010 << k), 16'h0000);
            wr(`OFS_CTRL_ONE, 16'h1C06 | (16'h0080 << k));
            repeat (8) @(posedge REF_CLK);
            rd(`OFS_CTRL_ONE, c0);
            chk(c0 & (16'h0070), 16'h0010 << k);
            measure(20);
            chk(high_cnt, 16'h0014);
            @(posedge REF_CLK);
            faults[k] <= 1'b0;
            wr(`OFS_CTRL_ONE, 16'h1C06 | (16'h0080 << k));
            repeat (30) @(posedge REF_CLK);
            measure(20);
            chk(high_cnt, 16'h0004);
        end
        test_done();
    end
endmodule
`default_nettype wire
